// File: pdp_defines.vh
/*
 Constants for the port direction and pull-up control block: register
 offsets, reset values and implemented-bit masks.
 Assumes an 8-bit data bus with 16-bit byte addresses.
*/
`ifndef PDP_DEFINES_VH
`define PDP_DEFINES_VH
`define PDP_ADDR_W 16
`define PDP_OFF_DIR0 16'hff20
`define PDP_OFF_DIR1 16'hff21
`define PDP_OFF_DIR2 16'hff22
`define PDP_OFF_DIR3 16'hff23
`define PDP_OFF_DIR5 16'hff25
`define PDP_OFF_DIR8 16'hff28
`define PDP_OFF_PU0 16'hff30
`define PDP_OFF_PU1 16'hff31
`define PDP_OFF_PU2 16'hff32
`define PDP_OFF_PU3 16'hff33
`define PDP_OFF_SEG7 16'hff57
`define PDP_OFF_SEG8 16'hff58
`define PDP_DIR_RESET 8'hff
`define PDP_PU_RESET 8'h00
`define PDP_SEG_RESET 8'h00
`define PDP_MASK_P0 8'hff
`define PDP_MASK_P1 8'h03
`define PDP_MASK_P2 8'h3f
`define PDP_MASK_P3 8'h1f
`define PDP_MASK_P5 8'h0f
`define PDP_MASK_P7 8'h0f
`define PDP_MASK_P8 8'hff
`define PDP_EXT_IRQ_N 4
`endif

// File: pdp_ctl_reg.v
/*
 One 8-bit control register with byte or single-bit write.
 Unimplemented bits hold a fixed value and ignore writes.
 Assumes write strobes are one cycle and synchronous to ref_clk.
*/
module pdp_ctl_reg #(
	parameter [7:0] RESET_VAL = 8'h00,
	parameter [7:0] IMPL_MASK = 8'hff
) (
	input wire ref_clk,
	input wire reset_n,
	input wire wr_byte,
	input wire wr_bit,
	input wire [2:0] bit_sel,
	input wire bit_val,
	input wire [7:0] wdata,
	output reg [7:0] value_q
);
	reg [7:0] value_d;
	always @* begin
		value_d = value_q;
		if (wr_byte) begin
			value_d = wdata;
		end else if (wr_bit) begin
			value_d[bit_sel] = bit_val;
		end
		// Fixed bits keep their reset value
		value_d = (value_d & IMPL_MASK) | (RESET_VAL & ~IMPL_MASK);
	end
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end
endmodule // pdp_ctl_reg

// File: pdp_port_ctl.v
/*
 Port direction, pull-up and port/segment selection control.
 Assumes one ref_clk domain, synchronous pin inputs and latch inputs,
 and single-cycle register strobes from the CPU.
*/
// Functional notes
// - Direction bit 1 means input, buffer off; 0 means output, buffer on.
// - Reset sets all direction registers to ones.
// - Direction registers take byte writes and single-bit writes.
// - Output-level change on an interrupt pin in output mode sets its request.
// - Port 8 direction acts only on pins selected for port use.
// - Pull-up bits exist for eight, two, six and five pins of ports 0-3.
// - Pull-up bit 1 connects the pull-up; 0 leaves it off.
// - Pull-up connects only when its bit is set and pin is input.
// - Output pins never get a pull-up, whatever the select bit.
// - Reset clears pull-up and port/segment selection registers.
// - Segment selection covers four port 7 pins and eight port 8 pins.
// - Segment bit 0 selects port use; 1 selects segment output.
// - With fixed-segment variants, segment writes are accepted but inert.
// - Pull-up and segment registers take byte and single-bit writes.
// - Latch write in input mode stores value, pin level unchanged.
// - Reads return latch in output mode, pin in input mode; latch kept.
`include "pdp_defines.vh"
module pdp_port_ctl #(
	parameter SEG_SELECT_EN = 1,
	parameter [7:0] FIXED_SEG7 = 8'h00,
	parameter [7:0] FIXED_SEG8 = 8'h00
) (
	input wire ref_clk,
	input wire reset_n,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_bit_wr,
	input wire [2:0] reg_bit_sel,
	input wire reg_bit_val,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	input wire [7:0] latch0,
	input wire [7:0] latch1,
	input wire [7:0] latch2,
	input wire [7:0] latch3,
	input wire [7:0] latch5,
	input wire [7:0] latch8,
	input wire [7:0] pin_in0,
	input wire [7:0] pin_in1,
	input wire [7:0] pin_in2,
	input wire [7:0] pin_in3,
	input wire [7:0] pin_in5,
	input wire [7:0] pin_in8,
	input wire [7:0] port_sel,
	input wire port_rd,
	output reg [7:0] port_rdata_q,
	output reg [7:0] out_en0_q,
	output reg [7:0] out_en1_q,
	output reg [7:0] out_en2_q,
	output reg [7:0] out_en3_q,
	output reg [7:0] out_en5_q,
	output reg [7:0] out_en8_q,
	output reg [7:0] pullup_en0_q,
	output reg [7:0] pullup_en1_q,
	output reg [7:0] pullup_en2_q,
	output reg [7:0] pullup_en3_q,
	output reg [7:0] seg_en7_q,
	output reg [7:0] seg_en8_q,
	output reg [3:0] ext_irq_set_q
);
	////////////////////////////////////////////////////////////////////////////
	// Register file
	wire [7:0] dir0_q, dir1_q, dir2_q, dir3_q, dir5_q, dir8_q;
	wire [7:0] pu0_q, pu1_q, pu2_q, pu3_q, seg7_q, seg8_q;
	wire [11:0] hit;
	wire [7:0] val [0:11];
	assign hit[0] = reg_addr == `PDP_OFF_DIR0;
	assign hit[1] = reg_addr == `PDP_OFF_DIR1;
	assign hit[2] = reg_addr == `PDP_OFF_DIR2;
	assign hit[3] = reg_addr == `PDP_OFF_DIR3;
	assign hit[4] = reg_addr == `PDP_OFF_DIR5;
	assign hit[5] = reg_addr == `PDP_OFF_DIR8;
	assign hit[6] = reg_addr == `PDP_OFF_PU0;
	assign hit[7] = reg_addr == `PDP_OFF_PU1;
	assign hit[8] = reg_addr == `PDP_OFF_PU2;
	assign hit[9] = reg_addr == `PDP_OFF_PU3;
	assign hit[10] = reg_addr == `PDP_OFF_SEG7;
	assign hit[11] = reg_addr == `PDP_OFF_SEG8;
	genvar g;
	generate
		for (g = 0; g < 12; g = g + 1) begin : g_reg
			// Direction regs reset to ones, others to zeros
			localparam [7:0] RV = (g < 6) ? `PDP_DIR_RESET :
				((g < 10) ? `PDP_PU_RESET : `PDP_SEG_RESET);
			// Implemented bits per register
			localparam [7:0] MK = (g == 1 || g == 7) ? `PDP_MASK_P1 :
				(g == 2 || g == 8) ? `PDP_MASK_P2 :
				(g == 3 || g == 9) ? `PDP_MASK_P3 :
				(g == 4 || g == 10) ? `PDP_MASK_P5 : 8'hff;
			pdp_ctl_reg #(
				.RESET_VAL(RV),
				.IMPL_MASK(MK)
			) u_reg (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.wr_byte(reg_wr & hit[g]),
				.wr_bit(reg_bit_wr & hit[g]),
				.bit_sel(reg_bit_sel),
				.bit_val(reg_bit_val),
				.wdata(reg_wdata),
				.value_q(val[g])
			);
		end
	endgenerate
	assign dir0_q = val[0];
	assign dir1_q = val[1];
	assign dir2_q = val[2];
	assign dir3_q = val[3];
	assign dir5_q = val[4];
	assign dir8_q = val[5];
	assign pu0_q = val[6];
	assign pu1_q = val[7];
	assign pu2_q = val[8];
	assign pu3_q = val[9];
	assign seg7_q = val[10];
	assign seg8_q = val[11];

	////////////////////////////////////////////////////////////////////////////
	// Register read: segment registers are write-only and read as zero
	reg [7:0] rdata_d;
	integer i;
	always @* begin
		rdata_d = 8'h00;
		for (i = 0; i < 10; i = i + 1) begin
			if (hit[i]) begin
				rdata_d = val[i];
			end
		end
	end
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Segment selection, inert when fixed at manufacture
	wire [7:0] seg7_eff = SEG_SELECT_EN ? seg7_q : FIXED_SEG7;
	wire [7:0] seg8_eff = SEG_SELECT_EN ? seg8_q : FIXED_SEG8;

	////////////////////////////////////////////////////////////////////////////
	// Pin controls
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_en0_q <= 8'h00;
			out_en1_q <= 8'h00;
			out_en2_q <= 8'h00;
			out_en3_q <= 8'h00;
			out_en5_q <= 8'h00;
			out_en8_q <= 8'h00;
			pullup_en0_q <= 8'h00;
			pullup_en1_q <= 8'h00;
			pullup_en2_q <= 8'h00;
			pullup_en3_q <= 8'h00;
			seg_en7_q <= 8'h00;
			seg_en8_q <= 8'h00;
		end else begin
			out_en0_q <= ~dir0_q & `PDP_MASK_P0;
			out_en1_q <= ~dir1_q & `PDP_MASK_P1;
			out_en2_q <= ~dir2_q & `PDP_MASK_P2;
			out_en3_q <= ~dir3_q & `PDP_MASK_P3;
			out_en5_q <= ~dir5_q & `PDP_MASK_P5;
			out_en8_q <= ~dir8_q & ~seg8_eff;
			pullup_en0_q <= pu0_q & dir0_q;
			pullup_en1_q <= pu1_q & dir1_q;
			pullup_en2_q <= pu2_q & dir2_q;
			pullup_en3_q <= pu3_q & dir3_q;
			seg_en7_q <= seg7_eff & `PDP_MASK_P7;
			seg_en8_q <= seg8_eff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request on output-level change of shared pins
	reg [3:0] lvl_q;
	wire [3:0] drv = (latch3[3:0] & ~dir3_q[3:0]) | (pin_in3[3:0] & dir3_q[3:0]);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lvl_q <= 4'h0;
			ext_irq_set_q <= 4'h0;
		end else begin
			lvl_q <= drv;
			ext_irq_set_q <= (drv ^ lvl_q) & ~dir3_q[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port read: latch in output mode, pin in input mode
	reg [7:0] prd_d;
	always @* begin
		case (port_sel)
			8'h00: prd_d = (latch0 & ~dir0_q) | (pin_in0 & dir0_q);
			8'h01: prd_d = ((latch1 & ~dir1_q) | (pin_in1 & dir1_q)) & `PDP_MASK_P1;
			8'h02: prd_d = ((latch2 & ~dir2_q) | (pin_in2 & dir2_q)) & `PDP_MASK_P2;
			8'h03: prd_d = ((latch3 & ~dir3_q) | (pin_in3 & dir3_q)) & `PDP_MASK_P3;
			8'h05: prd_d = ((latch5 & ~dir5_q) | (pin_in5 & dir5_q)) & `PDP_MASK_P5;
			8'h08: prd_d = ((latch8 & ~dir8_q) | (pin_in8 & dir8_q)) & ~seg8_eff;
			default: prd_d = 8'h00;
		endcase
	end
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_rdata_q <= 8'h00;
		end else if (port_rd) begin
			port_rdata_q <= prd_d;
		end
	end
endmodule // pdp_port_ctl

// File: pdp_port_ctl_assertions.sv
/* Timing checks on the port control block's pins.
 Bound into pdp_port_ctl; sees only its ports. */
module pdp_port_ctl_assertions (
	input wire ref_clk,
	input wire reset_n,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_bit_wr,
	input wire [2:0] reg_bit_sel,
	input wire reg_bit_val,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	input wire [7:0] latch3,
	input wire [7:0] out_en0_q,
	input wire [7:0] out_en3_q,
	input wire [7:0] out_en8_q,
	input wire [7:0] pullup_en0_q,
	input wire [7:0] pullup_en1_q,
	input wire [7:0] seg_en8_q,
	input wire [3:0] ext_irq_set_q
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!reset_n);
a_dir_byte_out: assert property (reg_wr && reg_addr == 16'hff20
	|-> ##2 out_en0_q == ~$past(reg_wdata, 2)) else $error("out_en0 wrong after byte write");
a_dir_bit_out: assert property (reg_bit_wr && !reg_wr && reg_addr == 16'hff20
	|-> ##2 out_en0_q[$past(reg_bit_sel, 2)] == !$past(reg_bit_val, 2))
	else $error("out_en0 wrong after bit write");
a_reset_clear: assert property ($rose(reset_n)
	|-> out_en0_q == 8'h00 && pullup_en0_q == 8'h00 && seg_en8_q == 8'h00)
	else $error("outputs not cleared by reset");
a_pullup_input_only: assert property ((pullup_en0_q & out_en0_q) == 8'h00)
	else $error("pull-up on output pin");
a_pullup_unused_bits: assert property (pullup_en1_q[7:2] == 6'h00)
	else $error("pull-up on missing pin");
a_seg_blocks_out: assert property ((seg_en8_q & out_en8_q) == 8'h00)
	else $error("segment pin drives port");
a_seg_read_zero: assert property (reg_rd && (reg_addr == 16'hff57 || reg_addr == 16'hff58)
	|=> reg_rdata_q == 8'h00) else $error("write-only register read nonzero");
a_irq_on_change: assert property ($changed(latch3[0]) ##1 (out_en3_q[0] && $past(out_en3_q[0]))
	|-> ext_irq_set_q[0]) else $error("no interrupt pulse");
a_irq_quiet_input: assert property (out_en3_q[3:0] == 4'h0 && $past(out_en3_q[3:0]) == 4'h0
	&& $past(out_en3_q[3:0], 3) == 4'h0 |-> ext_irq_set_q == 4'h0) else $error("stray pulse");
endmodule // pdp_port_ctl_assertions

bind pdp_port_ctl pdp_port_ctl_assertions u_chk (.ref_clk, .reset_n, .reg_addr, .reg_wr,
	.reg_bit_wr, .reg_bit_sel, .reg_bit_val, .reg_wdata, .reg_rd, .reg_rdata_q, .latch3,
	.out_en0_q, .out_en3_q, .out_en8_q, .pullup_en0_q, .pullup_en1_q, .seg_en8_q, .ext_irq_set_q);

// File: tb_pdp_port_ctl.sv
/* Self-checking bench for pdp_port_ctl.
 Drives every input at the falling edge; no far-side model. */
module tb_pdp_port_ctl;
timeunit 1ns;
timeprecision 1ns;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_bit_wr = 0, reg_bit_val = 0, reg_rd = 0;
logic port_rd = 0, seen;
logic [15:0] reg_addr = 0;
logic [2:0] reg_bit_sel = 0;
logic [7:0] reg_wdata = 0, lat = 0, pin = 0, port_sel = 0;
wire [7:0] rdata, prd, oe0, oe1, oe2, oe3, oe5, oe8, pu0, pu1, pu2, pu3, se7, se8;
wire [3:0] irq;
int failures = 0, checked = 0;
pdp_port_ctl DUT (.ref_clk, .reset_n, .reg_addr, .reg_wr, .reg_bit_wr, .reg_bit_sel,
	.reg_bit_val, .reg_wdata, .reg_rd, .reg_rdata_q(rdata), .latch0(lat), .latch1(lat),
	.latch2(lat), .latch3(lat), .latch5(lat), .latch8(lat), .pin_in0(pin), .pin_in1(pin),
	.pin_in2(pin), .pin_in3(pin), .pin_in5(pin), .pin_in8(pin), .port_sel, .port_rd,
	.port_rdata_q(prd), .out_en0_q(oe0), .out_en1_q(oe1), .out_en2_q(oe2), .out_en3_q(oe3),
	.out_en5_q(oe5), .out_en8_q(oe8), .pullup_en0_q(pu0), .pullup_en1_q(pu1),
	.pullup_en2_q(pu2), .pullup_en3_q(pu3), .seg_en7_q(se7), .seg_en8_q(se8),
	.ext_irq_set_q(irq));
////////////////////////////////////////////////////////////////////////////////
initial forever #20 ref_clk = ~ref_clk;
task automatic wr(input [15:0] a, input [7:0] d);
	@(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
	@(negedge ref_clk) reg_wr = 0;
endtask
task automatic bwr(input [15:0] a, input [2:0] s, input v);
	@(negedge ref_clk) {reg_addr, reg_bit_sel, reg_bit_val, reg_bit_wr} = {a, s, v, 1'b1};
	@(negedge ref_clk) reg_bit_wr = 0;
	@(negedge ref_clk);
endtask
task automatic rd(input [15:0] a, input [7:0] e);
	@(negedge ref_clk) {reg_addr, reg_rd} = {a, 1'b1};
	@(negedge ref_clk) reg_rd = 0;
	`CHK($sformatf("reg_rdata_q at %h", a), e, rdata)
endtask
task automatic prd_chk(input [7:0] s, input [7:0] e);
	@(negedge ref_clk) {port_sel, port_rd} = {s, 1'b1};
	@(negedge ref_clk) port_rd = 0;
	`CHK($sformatf("port_rdata_q of port %h", s), e, prd)
endtask
task automatic finish_test;
	$display("checks %0d mismatches %0d", checked, failures);
	if (failures == 0 && checked > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	#50us;
	failures++;
	finish_test();
end
initial begin
	static logic [15:0] ad [10] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23, 16'hff25,
		16'hff28, 16'hff30, 16'hff31, 16'hff32, 16'hff33};
	static logic [7:0] mk [10] = '{8'hff, 8'h03, 8'h3f, 8'h1f, 8'h0f, 8'hff, 8'hff, 8'h03,
		8'h3f, 8'h1f};
	repeat (20) @(negedge ref_clk);
	reset_n = 1;
	for (int i = 0; i < 10; i++) rd(ad[i], i < 6 ? 8'hff : 8'h00);
	rd(16'hff57, 8'h00);
	for (int i = 0; i < 10; i++) begin
		wr(ad[i], i < 6 ? 8'h00 : 8'hff);
		rd(ad[i], i < 6 ? ~mk[i] : mk[i]);
	end
	`CHK("out_en0_q", 8'hff, oe0)
	`CHK("pullup_en0_q", 8'h00, pu0)
	`CHK("out_en1_q", 8'h03, oe1)
	`CHK("out_en2_q", 8'h3f, oe2)
	`CHK("out_en5_q", 8'h0f, oe5)
	`CHK("pullup_en1_q", 8'h00, pu1)
	`CHK("pullup_en2_q", 8'h00, pu2)
	`CHK("pullup_en3_q", 8'h00, pu3)
	$display("test registers done");
	bwr(16'hff20, 3'd3, 1'b1);
	`CHK("out_en0_q", 8'hf7, oe0)
	`CHK("pullup_en0_q", 8'h08, pu0)
	rd(16'hff20, 8'h08);
	bwr(16'hff30, 3'd3, 1'b0);
	`CHK("pullup_en0_q", 8'h00, pu0)
	wr(16'hff58, 8'h0f);
	wr(16'hff57, 8'hff);
	@(negedge ref_clk);
	`CHK("seg_en8_q", 8'h0f, se8)
	`CHK("out_en8_q", 8'hf0, oe8)
	`CHK("seg_en7_q", 8'h0f, se7)
	rd(16'hff58, 8'h00);
	wr(16'hff40, 8'hff);
	rd(16'hff40, 8'h00);
	$display("test bits and segments done");
	{lat, pin} = {8'ha4, 8'h3c};
	prd_chk(8'h00, 8'hac);
	`CHK("out_en3_q", 8'h1f, oe3)
	wr(16'hff23, 8'h00);
	repeat (4) @(negedge ref_clk);
	lat = lat ^ 8'h01;
	seen = 0;
	repeat (4) @(negedge ref_clk) seen |= irq[0];
	`CHK("ext_irq_set_q", 1'b1, seen)
	wr(16'hff23, 8'hff);
	repeat (4) @(negedge ref_clk);
	lat = lat ^ 8'h01;
	seen = 0;
	repeat (4) @(negedge ref_clk) seen |= irq[0];
	`CHK("ext_irq_set_q", 1'b0, seen)
	prd_chk(8'h08, 8'ha0);
	prd_chk(8'h03, 8'h1c);
	prd_chk(8'h04, 8'h00);
	$display("test port read and interrupt done");
	reset_n = 0;
	repeat (2) @(negedge ref_clk);
	reset_n = 1;
	rd(16'hff20, 8'hff);
	rd(16'hff30, 8'h00);
	`CHK("out_en0_q", 8'h00, oe0)
	`CHK("seg_en8_q", 8'h00, se8)
	$display("test second reset done");
	finish_test();
end
endmodule // tb_pdp_port_ctl
